// [rtl/rdvq_pkg.sv]
// constants for the receive data-valid qualifier
// How it works
// RQ1: digital filter samples at 29 times the programmed bit rate
// RQ2: clock recovery makes a bit clock for the fifo or the pin
// RQ3: analog mode passes demodulated data with no bit clock or fifo load
// RQ4: bit rate spans 337 bps to 862 kbps, optional divide-by-ten prescaler
// RQ5: clock recovery has automatic, slow and fast modes
// RQ6: quality flag needs five good bits in a row, highs and lows
// RQ7: host keeps the quality threshold above 4 and at most 7
// RQ8: quality check runs only while the receiver is on
// RQ9: default mode holds data valid high
// RQ10: slow mode rises on all three flags, falls when all are low
// RQ11: medium mode is lock and either strength or quality
// RQ12: fast mode copies the quality flag
// RQ13: qualification off passes raw data, on passes only valid data
// RQ14: wake request only while data valid is asserted
// RQ15: sync upper byte fixed at 2d, lower byte set by host
// RQ16: strength threshold is a 3-bit field in control bits 2:0
// RQ17: status shows strength above threshold, visible only by reading
// RQ18: strength result gates the quality detect status bit 7
// RQ19: strength status sits at status bit 8
// RQ20: receiver off clears quality, lock and non-default data valid
package rdvq_pkg;
    // byte addresses
    localparam logic [7:0] RX_CTRL_ADDR = 8'h00;
    localparam logic [7:0] BB_FILT_ADDR = 8'h04;
    localparam logic [7:0] SYNC_CTRL_ADDR = 8'h08;
    localparam logic [7:0] RATE_ADDR = 8'h0c;
    localparam logic [7:0] STATUS_ADDR = 8'h10;
    // receiver_control_word fields
    localparam int STR_THR_LSB = 0;
    localparam int DV_MODE_LSB = 3;
    localparam int DV_EN_BIT = 5;
    localparam int RX_EN_BIT = 6;
    localparam logic [6:0] RX_CTRL_RST = 7'h00;
    // baseband_filter_control fields
    localparam int DIG_FILT_BIT = 0;
    localparam int CR_MODE_LSB = 1;
    localparam int QTHR_LSB = 3;
    localparam logic [5:0] BB_FILT_RST = 6'h29;
    // fifo_and_sync_control fields
    localparam int SYNC_WORD_BIT = 8;
    localparam int FIFO_USE_BIT = 9;
    localparam logic [9:0] SYNC_CTRL_RST = 10'h0d4;
    // rate_setting_control fields
    localparam int PRESC_BIT = 8;
    localparam logic [8:0] RATE_RST = 9'h000;
    // status_read_word bit positions
    localparam int ST_STRENGTH_BIT = 8;
    localparam int ST_QDETECT_BIT = 7;
    localparam int ST_LOCK_BIT = 6;
    localparam int ST_VALID_BIT = 5;
    localparam int ST_SYNC_BIT = 4;
    // fixed sync upper byte
    localparam logic [7:0] SYNC_UPPER = 8'h2d;
    // timing counts
    localparam logic [4:0] SAMPLES_PER_BIT = 5'h1d;
    localparam logic [3:0] PRESCALE_DIV = 4'ha;
    localparam logic [2:0] GOOD_BITS_NEEDED = 3'h5;
    localparam logic [2:0] LOCK_EDGES = 3'h4;
    localparam logic [4:0] EDGE_TOL = 5'h02;
    typedef enum logic [1:0] {
        CR_AUTO, CR_SLOW, CR_FAST, CR_SPARE
    } rdvq_cr_mode_type;
    typedef enum logic [1:0] {
        DV_DEFAULT, DV_SLOW, DV_MEDIUM, DV_FAST
    } rdvq_dv_mode_type;
endpackage : rdvq_pkg

// [rtl/rdvq_qualifier.sv]
// receive data-valid qualifier with its register slave
module rdvq_qualifier
    import rdvq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic demodData,
    input wire logic [2:0] strengthLevel,
    output logic dataValidOut,
    output logic rxDataOut,
    output logic recClkOut,
    output logic fifoLoadOut,
    output logic wakeReqOut
);
    logic [6:0] rxCtrl_ff;
    logic [5:0] bbFilt_ff;
    logic [9:0] syncCtrl_ff;
    logic [8:0] rate_ff;
    logic wrPend_ff;
    logic [7:0] wrAddr_ff;
    logic [31:0] hrdata_ff;
    logic hreadyout_ff;
    logic rxOn;
    logic digital;
    logic sampleEn;
    logic prevSample_ff;
    logic [4:0] phase_ff;
    logic [4:0] onesCnt_ff;
    logic [2:0] edgeCnt_ff;
    logic lock_ff;
    logic bitDone;
    logic bitVal;
    logic [4:0] agree;
    logic [2:0] qVal;
    logic [2:0] goodRun_ff;
    logic sawHigh_ff;
    logic sawLow_ff;
    logic qualityFlag_ff;
    logic strengthFlag_ff;
    logic [15:0] shift_ff;
    logic syncSeen_ff;
    logic syncHit;
    logic dataValid_ff;
    logic nxt_dataValid;
    logic recBit_ff;
    logic rxData_ff;
    logic recClk_ff;
    logic fifoLoad_ff;
    logic wakeReq_ff;
    logic edgeNow;
    logic edgeNear;
    logic useFast;
    logic [4:0] nxt_phase;
    logic phaseFixed_ff;
    logic [31:0] statusWord;
    rdvq_cr_mode_type crMode;
    rdvq_dv_mode_type dvMode;

    assign rxOn = rxCtrl_ff[RX_EN_BIT];
    assign digital = bbFilt_ff[DIG_FILT_BIT];
    assign crMode = rdvq_cr_mode_type'(bbFilt_ff[CR_MODE_LSB +: 2]);
    assign dvMode = rdvq_dv_mode_type'(rxCtrl_ff[DV_MODE_LSB +: 2]);

    // ahb-lite address phase capture and zero-wait read data
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wrPend_ff <= 1'b0;
            wrAddr_ff <= 8'h00;
            hrdata_ff <= 32'h0000_0000;
        end else if (hready) begin
            wrPend_ff <= hsel && htrans[1] && hwrite;
            wrAddr_ff <= haddr[7:0];
            if (hsel && htrans[1] && !hwrite) begin
                if (haddr[7:0] == RX_CTRL_ADDR) begin
                    hrdata_ff <= {25'h0, rxCtrl_ff};
                end else if (haddr[7:0] == BB_FILT_ADDR) begin
                    hrdata_ff <= {26'h0, bbFilt_ff};
                end else if (haddr[7:0] == SYNC_CTRL_ADDR) begin
                    hrdata_ff <= {22'h0, syncCtrl_ff};
                end else if (haddr[7:0] == RATE_ADDR) begin
                    hrdata_ff <= {23'h0, rate_ff};
                end else if (haddr[7:0] == STATUS_ADDR) begin
                    hrdata_ff <= statusWord; // RQ17
                end else begin
                    hrdata_ff <= 32'h0000_0000;
                end
            end
        end
    end

    // slave is always ready, always okay
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            hreadyout_ff <= 1'b1;
        end else begin
            hreadyout_ff <= 1'b1;
        end
    end

    // data phase register writes
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rxCtrl_ff <= RX_CTRL_RST;
            bbFilt_ff <= BB_FILT_RST;
            syncCtrl_ff <= SYNC_CTRL_RST;
            rate_ff <= RATE_RST;
        end else if (wrPend_ff) begin
            if (wrAddr_ff == RX_CTRL_ADDR) begin
                rxCtrl_ff <= hwdata[6:0]; // RQ16
            end else if (wrAddr_ff == BB_FILT_ADDR) begin
                bbFilt_ff <= hwdata[5:0];
            end else if (wrAddr_ff == SYNC_CTRL_ADDR) begin
                syncCtrl_ff <= hwdata[9:0]; // RQ15
            end else if (wrAddr_ff == RATE_ADDR) begin
                rate_ff <= hwdata[8:0]; // RQ4
            end
        end
    end

    // filter sample enable at 29 times the bit rate
    rdvq_rate_gen rateGen (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .run(rxOn && digital),
        .rateDiv(rate_ff[7:0]),
        .prescaleOn(rate_ff[PRESC_BIT]),
        .sampleEn(sampleEn)
    );

    // edge detection against the expected bit boundary
    assign edgeNow = sampleEn && (demodData != prevSample_ff);
    assign edgeNear = (phase_ff <= EDGE_TOL)
        || (phase_ff >= SAMPLES_PER_BIT - EDGE_TOL);
    assign useFast = (crMode == CR_FAST)
        || ((crMode == CR_AUTO) && !lock_ff); // RQ5
    assign bitDone = sampleEn && (phase_ff == SAMPLES_PER_BIT - 5'h01);

    // phase update: fast jumps to the edge, slow nudges by one sample
    always_comb begin
        nxt_phase = phase_ff + 5'h01;
        if (phase_ff == SAMPLES_PER_BIT - 5'h01) begin
            nxt_phase = 5'h00;
        end
        if (edgeNow && phase_ff != 5'h00 && !phaseFixed_ff) begin
            if (useFast) begin
                nxt_phase = 5'h01; // RQ5
            end else if (phase_ff < 5'h0f) begin
                nxt_phase = phase_ff; // RQ5
            end else if (phase_ff < SAMPLES_PER_BIT - 5'h02) begin
                nxt_phase = phase_ff + 5'h02;
            end else begin
                nxt_phase = 5'h00;
            end
        end
    end

    // bit phase counter, previous sample, one correction per bit
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !rxOn || !digital) begin
            phase_ff <= 5'h00;
            prevSample_ff <= 1'b0;
            phaseFixed_ff <= 1'b0;
        end else if (sampleEn) begin
            phase_ff <= nxt_phase; // RQ2
            prevSample_ff <= demodData;
            phaseFixed_ff <= !bitDone
                && (phaseFixed_ff || (edgeNow && phase_ff != 5'h00)); // RQ5
        end
    end

    // lock: several edges in a row near the boundary
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !rxOn || !digital) begin
            edgeCnt_ff <= 3'h0;
            lock_ff <= 1'b0; // RQ20
        end else if (edgeNow) begin
            if (!edgeNear) begin
                edgeCnt_ff <= 3'h0;
                lock_ff <= 1'b0;
            end else if (edgeCnt_ff < LOCK_EDGES) begin
                edgeCnt_ff <= edgeCnt_ff + 3'h1;
            end else begin
                lock_ff <= 1'b1;
            end
        end
    end

    // count ones within the bit window
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !rxOn || !digital) begin
            onesCnt_ff <= 5'h00;
        end else if (sampleEn) begin
            if (bitDone) begin
                onesCnt_ff <= 5'h00;
            end else begin
                onesCnt_ff <= onesCnt_ff + {4'h0, demodData};
            end
        end
    end

    // per-bit decision and quality value 3..7
    assign bitVal = (onesCnt_ff + {4'h0, demodData}) > 5'h0e;
    assign agree = bitVal ? onesCnt_ff + {4'h0, demodData}
        : SAMPLES_PER_BIT - onesCnt_ff - {4'h0, demodData};
    assign qVal = agree[4:2];

    // five consecutive good bits covering both levels
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !rxOn || !digital) begin
            goodRun_ff <= 3'h0; // RQ8
            sawHigh_ff <= 1'b0;
            sawLow_ff <= 1'b0;
            qualityFlag_ff <= 1'b0; // RQ20
        end else if (bitDone) begin
            if (qVal <= bbFilt_ff[QTHR_LSB +: 3]) begin
                goodRun_ff <= 3'h0;
                sawHigh_ff <= 1'b0;
                sawLow_ff <= 1'b0;
                qualityFlag_ff <= 1'b0;
            end else begin
                if (goodRun_ff < GOOD_BITS_NEEDED) begin
                    goodRun_ff <= goodRun_ff + 3'h1;
                end
                sawHigh_ff <= sawHigh_ff || bitVal;
                sawLow_ff <= sawLow_ff || !bitVal;
                if (goodRun_ff >= GOOD_BITS_NEEDED - 3'h1
                    && (sawHigh_ff || bitVal) && (sawLow_ff || !bitVal)) begin
                    qualityFlag_ff <= 1'b1; // RQ6
                end
            end
        end
    end

    // digital strength comparator
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !rxOn) begin
            strengthFlag_ff <= 1'b0;
        end else begin
            strengthFlag_ff <= strengthLevel > rxCtrl_ff[STR_THR_LSB +: 3]; // RQ17
        end
    end

    // sync pattern search on recovered bits
    assign syncHit = syncCtrl_ff[SYNC_WORD_BIT]
        ? ({shift_ff[14:0], bitVal} == {SYNC_UPPER, syncCtrl_ff[7:0]})
        : ({shift_ff[6:0], bitVal} == syncCtrl_ff[7:0]); // RQ15

    always_ff @(posedge sys_clk) begin
        if (!rst_b || !rxOn || !digital) begin
            shift_ff <= 16'h0000;
            syncSeen_ff <= 1'b0;
        end else if (bitDone) begin
            shift_ff <= {shift_ff[14:0], bitVal};
            if (syncHit) begin
                syncSeen_ff <= 1'b1;
            end
        end
    end

    // data valid combining per response mode
    always_comb begin
        nxt_dataValid = 1'b0;
        case (dvMode)
            DV_DEFAULT: nxt_dataValid = 1'b1; // RQ9
            DV_SLOW: begin
                if (strengthFlag_ff && qualityFlag_ff && lock_ff) begin
                    nxt_dataValid = 1'b1; // RQ10
                end else if (!strengthFlag_ff && !qualityFlag_ff
                    && !lock_ff) begin
                    nxt_dataValid = 1'b0; // RQ10
                end else begin
                    nxt_dataValid = dataValid_ff;
                end
            end
            DV_MEDIUM: begin
                nxt_dataValid = lock_ff
                    && (strengthFlag_ff || qualityFlag_ff); // RQ11
            end
            DV_FAST: nxt_dataValid = qualityFlag_ff; // RQ12
            default: nxt_dataValid = 1'b0;
        endcase
        if (!rxOn && dvMode != DV_DEFAULT) begin
            nxt_dataValid = 1'b0; // RQ20
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            dataValid_ff <= 1'b0;
        end else begin
            dataValid_ff <= nxt_dataValid;
        end
    end

    // recovered bit held for one bit period
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !rxOn || !digital) begin
            recBit_ff <= 1'b0;
        end else if (bitDone) begin
            recBit_ff <= bitVal;
        end
    end

    // output data path: raw, qualified digital, or analog pass-through
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !rxOn) begin
            rxData_ff <= 1'b0;
        end else if (!rxCtrl_ff[DV_EN_BIT] || !digital) begin
            rxData_ff <= demodData; // RQ3 RQ13
        end else begin
            rxData_ff <= recBit_ff && dataValid_ff; // RQ13
        end
    end

    // bit clock to the pin or fifo load strobe, digital mode only
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !rxOn || !digital) begin
            recClk_ff <= 1'b0; // RQ3
            fifoLoad_ff <= 1'b0;
        end else begin
            recClk_ff <= !syncCtrl_ff[FIFO_USE_BIT]
                && (phase_ff < 5'h0f); // RQ2
            fifoLoad_ff <= syncCtrl_ff[FIFO_USE_BIT] && bitDone; // RQ2
        end
    end

    // host wake request only while qualified valid data is present
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !rxOn) begin
            wakeReq_ff <= 1'b0;
        end else begin
            wakeReq_ff <= rxCtrl_ff[DV_EN_BIT] && nxt_dataValid
                && dvMode != DV_DEFAULT; // RQ14
        end
    end

    // status word, quality detect gated by strength
    always_comb begin
        statusWord = 32'h0000_0000;
        statusWord[ST_STRENGTH_BIT] = strengthFlag_ff; // RQ19
        statusWord[ST_QDETECT_BIT] = qualityFlag_ff && strengthFlag_ff; // RQ18
        statusWord[ST_LOCK_BIT] = lock_ff;
        statusWord[ST_VALID_BIT] = dataValid_ff;
        statusWord[ST_SYNC_BIT] = syncSeen_ff;
    end

    assign hrdata = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp = 1'b0;
    assign dataValidOut = dataValid_ff;
    assign rxDataOut = rxData_ff;
    assign recClkOut = recClk_ff;
    assign fifoLoadOut = fifoLoad_ff;
    assign wakeReqOut = wakeReq_ff;
endmodule : rdvq_qualifier

// [rtl/rdvq_rate_gen.sv]
// sample-rate enable divider for the digital filter
module rdvq_rate_gen
    import rdvq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic [7:0] rateDiv,
    input wire logic prescaleOn,
    output logic sampleEn
);
    logic [3:0] preCnt_ff;
    logic [7:0] divCnt_ff;
    logic preTick;

    // optional divide-by-ten stage for fine low-rate steps
    assign preTick = !prescaleOn || (preCnt_ff == PRESCALE_DIV - 4'h1); // RQ4

    always_ff @(posedge sys_clk) begin
        if (!rst_b || !run || !prescaleOn) begin
            preCnt_ff <= 4'h0;
        end else if (preTick) begin
            preCnt_ff <= 4'h0;
        end else begin
            preCnt_ff <= preCnt_ff + 4'h1;
        end
    end

    // main divider, sample rate is clock / (rateDiv+1) / prescale
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !run) begin
            divCnt_ff <= 8'h00;
        end else if (preTick) begin
            if (divCnt_ff >= rateDiv) begin
                divCnt_ff <= 8'h00;
            end else begin
                divCnt_ff <= divCnt_ff + 8'h01;
            end
        end
    end

    // one-cycle enable at 29 times the bit rate
    assign sampleEn = run && preTick && (divCnt_ff >= rateDiv); // RQ1 RQ4
endmodule : rdvq_rate_gen

// [sim/rdvq_qualifier_checker.sv]
// port assertions for the receive data-valid qualifier
module rdvq_qualifier_checker
    import rdvq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic demodData,
    input wire logic [2:0] strengthLevel,
    input wire logic dataValidOut,
    input wire logic rxDataOut,
    input wire logic recClkOut,
    input wire logic fifoLoadOut,
    input wire logic wakeReqOut
);
    timeunit 1ns;
    timeprecision 1ns;
    logic wrCtrl_ff;
    logic [6:0] ctrl_ff;
    logic [1:0] settle_ff;
    logic [1:0] dvMode;
    assign dvMode = ctrl_ff[DV_MODE_LSB +: 2];
    // shadow of the control word, settle count since its last write
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wrCtrl_ff <= 1'b0;
            ctrl_ff <= RX_CTRL_RST;
            settle_ff <= 2'h0;
        end else if (hready) begin
            wrCtrl_ff <= hsel && htrans[1] && hwrite && haddr == 32'h0;
            if (wrCtrl_ff) begin
                ctrl_ff <= hwdata[6:0];
                settle_ff <= 2'h0;
            end else if (settle_ff != 2'h3) begin
                settle_ff <= settle_ff + 2'h1;
            end
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    chk_ready_always: assert property (hreadyout)
        else $error("hreadyout low");
    chk_resp_okay: assert property (!hresp)
        else $error("hresp not okay");
    chk_reset_quiet: assert property ($rose(rst_b) |->
        !fifoLoadOut && !wakeReqOut && !recClkOut)
        else $error("outputs not cleared by reset");
    chk_load_spaced: assert property (fifoLoadOut |=> !fifoLoadOut[*8])
        else $error("fifo load pulses too close");
    chk_wake_valid: assert property (wakeReqOut |-> dataValidOut)
        else $error("wake without data valid");
    chk_upper_zero: assert property (hrdata[31:10] == 22'h0)
        else $error("read data upper bits set");
    chk_default_high: assert property (settle_ff == 2'h3 &&
        dvMode == DV_DEFAULT |-> dataValidOut)
        else $error("default mode data valid low");
    chk_rxoff_low: assert property (settle_ff == 2'h3 &&
        !ctrl_ff[RX_EN_BIT] && dvMode != DV_DEFAULT |-> !dataValidOut)
        else $error("data valid high with receiver off");
    chk_wake_gated: assert property (settle_ff == 2'h3 &&
        (!ctrl_ff[DV_EN_BIT] || dvMode == DV_DEFAULT) |-> !wakeReqOut)
        else $error("wake while qualification unused");
    chk_raw_pass: assert property (settle_ff == 2'h3 &&
        ctrl_ff[RX_EN_BIT] && !ctrl_ff[DV_EN_BIT]
        |-> rxDataOut == $past(demodData))
        else $error("raw data not passed through");
    cover property ($rose(dataValidOut));
    cover property (fifoLoadOut);
    cover property ($rose(recClkOut));
endmodule : rdvq_qualifier_checker

bind rdvq_qualifier rdvq_qualifier_checker u_chk (.sys_clk(sys_clk),
    .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .demodData(demodData), .strengthLevel(strengthLevel),
    .dataValidOut(dataValidOut), .rxDataOut(rxDataOut),
    .recClkOut(recClkOut), .fifoLoadOut(fifoLoadOut),
    .wakeReqOut(wakeReqOut));

// [sim/rdvq_radio_model.sv]
// demodulator stand-in giving bit patterns at the bit rate
module rdvq_radio_model
    import rdvq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [1:0] pattern,
    output logic demodData
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] phase_ff;
    // bit timer for rate divider zero, no prescaler
    always_ff @(posedge sys_clk) begin
        if (!rst_b || phase_ff == SAMPLES_PER_BIT - 5'h01) begin
            phase_ff <= 5'h00;
        end else begin
            phase_ff <= phase_ff + 5'h01;
        end
    end
    // 1 alternates per bit, 2 holds one, 3 is noise, 0 holds zero
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            demodData <= 1'b0;
        end else begin
            case (pattern)
                2'h1: demodData <= (phase_ff == 5'h00) ? !demodData : demodData;
                2'h2: demodData <= 1'b1;
                2'h3: demodData <= !demodData;
                default: demodData <= 1'b0;
            endcase
        end
    end
endmodule : rdvq_radio_model

// [sim/testbench.sv]
// self-checking bench for the receive data-valid qualifier
module testbench
    import rdvq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, rst_b, hsel, hwrite, hreadyout, hresp, demodData;
    logic dataValidOut, rxDataOut, recClkOut, fifoLoadOut, wakeReqOut;
    logic prevDemod, prevClk;
    logic [1:0] htrans, pattern;
    logic [2:0] strengthLevel;
    logic [31:0] haddr, hwdata, hrdata, rdData;
    logic [31:0] rstVal [4];
    int errorCnt, testsRun, loads, rises, waited;
    rdvq_qualifier dut (.sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .demodData(demodData),
        .strengthLevel(strengthLevel), .dataValidOut(dataValidOut),
        .rxDataOut(rxDataOut), .recClkOut(recClkOut),
        .fifoLoadOut(fifoLoadOut), .wakeReqOut(wakeReqOut));
    rdvq_radio_model u_radio (.sys_clk(sys_clk), .rst_b(rst_b),
        .pattern(pattern), .demodData(demodData));
    // 25 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task endSim;
        $display("checks %0d mismatches %0d", testsRun, errorCnt);
        if (errorCnt == 0 && testsRun > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : endSim
    task check(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errorCnt++;
            $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
        end
    endtask : check
    task waitReady;
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            errorCnt++;
            $display("CHECK FAILED %0t bus timeout", $time);
            endSim();
        end
    endtask : waitReady
    task busXfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        waitReady();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        waitReady();
        rdData = hrdata;
    endtask : busXfer
    task waitValid(input logic lvl, input int limit);
        waited = 0;
        while (dataValidOut !== lvl && waited < limit) begin
            @(posedge sys_clk);
            waited++;
        end
        check(dataValidOut, lvl);
        if (dataValidOut !== lvl) begin
            endSim();
        end
    endtask : waitValid
    task countPins(input int cycles);
        loads = 0;
        rises = 0;
        repeat (cycles) begin
            prevClk = recClkOut;
            @(posedge sys_clk);
            loads += fifoLoadOut;
            rises += (recClkOut && !prevClk);
        end
    endtask : countPins
    // bound on the whole run
    initial begin
        repeat (100000) @(posedge sys_clk);
        errorCnt++;
        $display("CHECK FAILED %0t run timeout", $time);
        endSim();
    end
    // main sequence
    initial begin
        rst_b = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        strengthLevel = 3'h0;
        pattern = 2'h0;
        rstVal = '{{25'h0, RX_CTRL_RST}, {26'h0, BB_FILT_RST},
            {22'h0, SYNC_CTRL_RST}, {23'h0, RATE_RST}};
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        busXfer(1'b1, 32'h14, 32'hffffffff);
        busXfer(1'b0, 32'h14, 32'h0);
        check(rdData, 32'h0);
        for (int i = 0; i < 4; i++) begin
            busXfer(1'b0, 32'(i * 4), 32'h0);
            check(rdData, rstVal[i]);
        end
        check(dataValidOut, 1'b1);
        check(wakeReqOut, 1'b0);
        strengthLevel <= 3'h3;
        busXfer(1'b1, 32'h0, 32'h42);
        @(posedge sys_clk);
        busXfer(1'b0, 32'h10, 32'h0);
        check(rdData[8], 1'b1);
        busXfer(1'b1, 32'h0, 32'h43);
        @(posedge sys_clk);
        busXfer(1'b0, 32'h10, 32'h0);
        check(rdData[8:7], 2'h0);
        busXfer(1'b1, 32'h0, 32'h02);
        pattern <= 2'h1;
        busXfer(1'b1, 32'h0, 32'h7a);
        waitValid(1'b0, 10);
        waitValid(1'b1, 1000);
        check(waited >= 4 * SAMPLES_PER_BIT, 1'b1);
        check(wakeReqOut, 1'b1);
        busXfer(1'b0, 32'h10, 32'h0);
        check(rdData[8:7], 2'h3);
        countPins(290);
        check(loads, 0);
        check(rises >= 9, 1'b1);
        pattern <= 2'h3;
        waitValid(1'b0, 400);
        pattern <= 2'h1;
        waitValid(1'b1, 1000);
        busXfer(1'b1, 32'h0, 32'h3a);
        waitValid(1'b0, 10);
        busXfer(1'b0, 32'h10, 32'h0);
        check(rdData[8:5], 4'h0);
        for (int m = 1; m < 4; m++) begin
            busXfer(1'b1, 32'h0, 32'h02);
            busXfer(1'b1, 32'h0, 32'h62 | 32'(m << 3));
            waitValid(1'b0, 10);
            waitValid(1'b1, 1000);
        end
        busXfer(1'b1, 32'h0, 32'h6a);
        strengthLevel <= 3'h0;
        countPins(60);
        check(dataValidOut, 1'b1);
        busXfer(1'b0, 32'h10, 32'h0);
        check(rdData[8:6], 3'h1);
        pattern <= 2'h3;
        waitValid(1'b0, 1000);
        busXfer(1'b1, 32'h4, 32'h28);
        countPins(5);
        prevDemod = demodData;
        repeat (60) begin
            @(posedge sys_clk);
            check({rxDataOut, recClkOut, fifoLoadOut}, {prevDemod, 2'h0});
            prevDemod = demodData;
        end
        busXfer(1'b1, 32'h4, 32'h29);
        busXfer(1'b1, 32'h8, 32'h2d4);
        pattern <= 2'h1;
        countPins(200);
        countPins(290);
        check(loads >= 9 && loads <= 10, 1'b1);
        check(rises, 0);
        busXfer(1'b1, 32'h8, 32'h3aa);
        countPins(290);
        busXfer(1'b0, 32'h10, 32'h0);
        check(rdData[4], 1'b0);
        busXfer(1'b1, 32'h8, 32'h2aa);
        countPins(290);
        busXfer(1'b0, 32'h10, 32'h0);
        check(rdData[4], 1'b1);
        pattern <= 2'h0;
        busXfer(1'b1, 32'hc, 32'h100);
        countPins(300);
        countPins(580);
        check(loads, 2);
        busXfer(1'b1, 32'hc, 32'h001);
        countPins(60);
        countPins(290);
        check(loads, 5);
        endSim();
    end
endmodule : testbench
